// ### iops_board_model.sv
// Board side: supply monitors and the shared pull-up select pin
`timescale 1ns/1ns
`default_nettype none
module iops_board_model (
  input wire logic core_clk,
  input wire logic [2:0] sup_on,
  input wire logic sel_open,
  input wire logic sel_level,
  input wire logic sel_pin_weak_pullup_r,
  input wire logic sel_pin_oe_n_r,
  input wire logic sel_pin_out_r,
  output logic vccint_ok,
  output logic vccaux_ok,
  output logic vcco2_ok,
  output logic config_pullup_select_n
);
  logic [2:0] sup_r = 3'h0;
  logic float_r = 1'b0;
  always @(posedge core_clk) begin
    sup_r <= sup_on;
    float_r <= ~float_r;
  end
  assign vccint_ok = sup_r[0];
  assign vccaux_ok = sup_r[1];
  assign vcco2_ok = sup_r[2];
  // pin level from all drivers
  // Undriven and unpulled pin wanders, so a stale level never passes
  assign config_pullup_select_n = !sel_pin_oe_n_r ? sel_pin_out_r :
    !sel_open ? sel_level : sel_pin_weak_pullup_r ? 1'b1 : float_r;
endmodule
`default_nettype wire

// ### iops_defines.vh
// Register map, fields and reset values of the I/O power-up sequencer
`ifndef IOPS_DEFINES_VH
`define IOPS_DEFINES_VH

// ****************************************
// Register byte offsets
// ****************************************
`define IOPS_ADDR_CTRL 8'h00
`define IOPS_ADDR_STATUS 8'h04
`define IOPS_ADDR_USED 8'h08
`define IOPS_ADDR_SRINV 8'h0C
`define IOPS_ADDR_UPULL 8'h10
`define IOPS_ADDR_DOUT 8'h14
`define IOPS_ADDR_SELPIN 8'h18

// ****************************************
// Control fields
// ****************************************
`define IOPS_CTRL_TERM_LSB 0
`define IOPS_CTRL_TERM_MSB 1
`define IOPS_CTRL_DLY_LSB 2
`define IOPS_CTRL_DLY_MSB 5
`define IOPS_TERM_PULLDOWN 2'h0
`define IOPS_TERM_PULLUP 2'h1
`define IOPS_TERM_FLOAT 2'h2
`define IOPS_GWE_DLY_RST 4'h1

// ****************************************
// Status fields
// ****************************************
`define IOPS_ST_STATE_LSB 0
`define IOPS_ST_STATE_MSB 2
`define IOPS_ST_MODE_LSB 3
`define IOPS_ST_MODE_MSB 5
`define IOPS_ST_GSR 6
`define IOPS_ST_GTS 7
`define IOPS_ST_GWE 8
`define IOPS_ST_INIT 9
`define IOPS_ST_SELPIN 10

// ****************************************
// Select-pin register fields
// ****************************************
`define IOPS_SEL_OUT 0
`define IOPS_SEL_DRV 1

`endif

// ### iops_delay_count.v
// Load-and-count delay timer with a one-cycle done pulse
`timescale 1ns/1ns
`default_nettype none

module iops_delay_count #(
  parameter CW = 16
) (
  input wire core_clk,
  input wire rstn,
  input wire start,
  input wire [CW-1:0] load_val,
  output reg busy_r,
  output reg done_r
);

  reg [CW-1:0] cnt_r;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= {CW{1'b0}};
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        cnt_r <= load_val;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        // Done fires when count reaches one, so N loads give N cycles
        if (cnt_r <= {{(CW-1){1'b0}}, 1'b1}) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

`default_nettype wire

// ### iops_sequencer.v
// I/O power-on, configuration and start-up sequencer with Wishbone registers
//
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "iops_defines.vh"

// Summary of operation
// - Until configuration starts all output drivers sit in high impedance.
// - Configuration waits until core, auxiliary and bank 2 supplies are all good.
// - A low pull-up select pin enables pull-ups up to three-state release; high lets pins float.
// - The pull-up select pin carries a weak internal pull-up until user mode so it reads high when open.
// - At power-up the configuration memory is cleared and global set-reset forces cells low.
// - When initialization ends the init status pin rises and the mode inputs are sampled.
// - While configuration loads the drivers stay high impedance with pulls per the select pin.
// - Global set-reset releases at end of configuration; cells start low unless inverted.
// - Start-up releases global three-state; used pins go active, unused pull down by default.
// - Unused pin termination after release is pull-up, pull-down or float, pull-down default.
// - Global write enable releases one cycle after three-state release by default.
// - In user mode pull-ups follow the design and the select pin becomes a plain I/O.
// - Input-only and idle dual-purpose pins follow the same sequence as ordinary I/O.
module iops_sequencer #(
  parameter NUM_IO = 8,
  parameter CLEAR_CYCLES = 16,
  parameter CW = 16
) (
  input wire core_clk,
  input wire rstn,
  input wire vccint_ok,
  input wire vccaux_ok,
  input wire vcco2_ok,
  input wire config_pullup_select_n,
  input wire config_mode_sel_0,
  input wire config_mode_sel_1,
  input wire config_mode_sel_2,
  input wire cfg_load_done,
  output reg init_status_r,
  output reg [2:0] config_mode_r,
  output reg global_set_reset_r,
  output reg global_three_state_r,
  output reg global_write_enable_r,
  output reg [NUM_IO-1:0] io_oe_n_r,
  output reg [NUM_IO-1:0] io_dout_r,
  output reg [NUM_IO-1:0] io_pullup_en_r,
  output reg [NUM_IO-1:0] io_pulldown_en_r,
  output reg [NUM_IO-1:0] io_block_cell_init_r,
  output reg sel_pin_weak_pullup_r,
  output reg sel_pin_oe_n_r,
  output reg sel_pin_out_r,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o
);

  // ****************************************
  // States
  // ****************************************
  localparam [2:0] ST_CLEAR = 3'h0;
  localparam [2:0] ST_CONFIG = 3'h1;
  localparam [2:0] ST_REL_GSR = 3'h2;
  localparam [2:0] ST_REL_GTS = 3'h3;
  localparam [2:0] ST_WAIT_GWE = 3'h4;
  localparam [2:0] ST_USER = 3'h5;

  localparam [CW-1:0] CLEAR_LOAD = CLEAR_CYCLES[CW-1:0];

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg clr_start_r;
  reg gwe_start_r;
  reg [1:0] term_r;
  reg [3:0] gwe_dly_r;
  reg [NUM_IO-1:0] used_r;
  reg [NUM_IO-1:0] srinv_r;
  reg [NUM_IO-1:0] upull_r;
  reg [NUM_IO-1:0] dout_r;
  reg sel_out_r;
  reg sel_drv_r;
  wire clr_busy;
  wire clr_done;
  wire gwe_busy;
  wire gwe_done;
  wire supplies_ok;
  wire wb_req;
  wire wb_wr;
  reg [31:0] rd_data;
  wire [31:0] wr_merged;
  reg [NUM_IO-1:0] pull_up_nxt;
  reg [NUM_IO-1:0] pull_dn_nxt;

  assign supplies_ok = vccint_ok & vccaux_ok & vcco2_ok;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;

  // Byte-lane merge used by every writable register except the select-pin register
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer i;
    begin
      lane_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          lane_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // ****************************************
  // Timers
  // ****************************************
  iops_delay_count #(.CW(CW)) u_clear_tmr (
    .core_clk(core_clk),
    .rstn(rstn),
    .start(clr_start_r),
    .load_val(CLEAR_LOAD),
    .busy_r(clr_busy),
    .done_r(clr_done)
  );

  iops_delay_count #(.CW(CW)) u_gwe_tmr (
    .core_clk(core_clk),
    .rstn(rstn),
    .start(gwe_start_r),
    .load_val({{(CW-4){1'b0}}, gwe_dly_r - 4'h1}),
    .busy_r(gwe_busy),
    .done_r(gwe_done)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_CLEAR: begin
        if (!clr_busy && !clr_start_r && supplies_ok) begin
          state_nxt = ST_CONFIG;
        end
      end
      ST_CONFIG: begin
        if (cfg_load_done) begin
          state_nxt = ST_REL_GSR;
        end
      end
      // zero delay frees write enable with three-state
      ST_REL_GSR: begin
        if (gwe_dly_r == 4'h0) begin
          state_nxt = ST_USER;
        end else begin
          state_nxt = ST_REL_GTS;
        end
      end
      ST_REL_GTS: begin
        if (gwe_dly_r <= 4'h1) begin
          state_nxt = ST_USER;
        end else begin
          state_nxt = ST_WAIT_GWE;
        end
      end
      ST_WAIT_GWE: begin
        if (gwe_done) begin
          state_nxt = ST_USER;
        end
      end
      ST_USER: begin
        state_nxt = ST_USER;
      end
      default: begin
        state_nxt = ST_CLEAR;
      end
    endcase
    // Supply loss restarts the whole sequence from memory clear
    if (!supplies_ok && state_r != ST_CLEAR) begin
      state_nxt = ST_CLEAR;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_CLEAR;
      clr_start_r <= 1'b1;
      gwe_start_r <= 1'b0;
      init_status_r <= 1'b0;
      config_mode_r <= 3'h0;
      global_set_reset_r <= 1'b1;
      global_three_state_r <= 1'b1;
      global_write_enable_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      clr_start_r <= (state_r != ST_CLEAR) && (state_nxt == ST_CLEAR);
      // Start is raised at set-reset release, so the timer loads at three-state release and its done pulse lands on time
      gwe_start_r <= (state_r == ST_CONFIG) && (state_nxt == ST_REL_GSR) && (gwe_dly_r > 4'h1);
      if (state_nxt == ST_CLEAR) begin
        init_status_r <= 1'b0;
        global_set_reset_r <= 1'b1;
        global_three_state_r <= 1'b1;
        global_write_enable_r <= 1'b0;
      end
      if (state_r == ST_CLEAR && state_nxt == ST_CONFIG) begin
        init_status_r <= 1'b1;
        config_mode_r <= {config_mode_sel_2, config_mode_sel_1, config_mode_sel_0};
      end
      if (state_r == ST_CONFIG && state_nxt == ST_REL_GSR) begin
        global_set_reset_r <= 1'b0;
      end
      if (state_r == ST_REL_GSR && state_nxt != ST_CLEAR) begin
        global_three_state_r <= 1'b0;
      end
      if (state_nxt == ST_USER && state_r != ST_USER) begin
        global_write_enable_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // Pin control
  // ****************************************
  always @* begin
    pull_up_nxt = {NUM_IO{1'b0}};
    pull_dn_nxt = {NUM_IO{1'b0}};
    if (global_three_state_r) begin
      pull_up_nxt = {NUM_IO{~config_pullup_select_n}};
    end else begin
      pull_up_nxt = used_r & upull_r;
      if (term_r == `IOPS_TERM_PULLUP) begin
        pull_up_nxt = pull_up_nxt | ~used_r;
      end else if (term_r == `IOPS_TERM_PULLDOWN) begin
        pull_dn_nxt = ~used_r;
      end
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      io_oe_n_r <= {NUM_IO{1'b1}};
      io_dout_r <= {NUM_IO{1'b0}};
      io_pullup_en_r <= {NUM_IO{1'b0}};
      io_pulldown_en_r <= {NUM_IO{1'b0}};
      io_block_cell_init_r <= {NUM_IO{1'b0}};
      sel_pin_weak_pullup_r <= 1'b1;
      sel_pin_oe_n_r <= 1'b1;
      sel_pin_out_r <= 1'b0;
    end else begin
      io_pullup_en_r <= pull_up_nxt;
      io_pulldown_en_r <= pull_dn_nxt;
      if (global_three_state_r) begin
        io_oe_n_r <= {NUM_IO{1'b1}};
      end else begin
        io_oe_n_r <= ~used_r;
      end
      io_dout_r <= dout_r;
      // cells low, inverted ones high after release
      if (global_set_reset_r) begin
        io_block_cell_init_r <= {NUM_IO{1'b0}};
      end else begin
        io_block_cell_init_r <= srinv_r;
      end
      // select pin pulled until user mode, then plain I/O
      if (state_r == ST_USER) begin
        sel_pin_weak_pullup_r <= 1'b0;
        sel_pin_oe_n_r <= ~sel_drv_r;
        sel_pin_out_r <= sel_out_r;
      end else begin
        sel_pin_weak_pullup_r <= 1'b1;
        sel_pin_oe_n_r <= 1'b1;
        sel_pin_out_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Wishbone registers
  // ****************************************
  always @* begin
    rd_data = 32'h0;
    if (wb_adr_i == `IOPS_ADDR_CTRL) begin
      rd_data[`IOPS_CTRL_TERM_MSB:`IOPS_CTRL_TERM_LSB] = term_r;
      rd_data[`IOPS_CTRL_DLY_MSB:`IOPS_CTRL_DLY_LSB] = gwe_dly_r;
    end else if (wb_adr_i == `IOPS_ADDR_STATUS) begin
      rd_data[`IOPS_ST_STATE_MSB:`IOPS_ST_STATE_LSB] = state_r;
      rd_data[`IOPS_ST_MODE_MSB:`IOPS_ST_MODE_LSB] = config_mode_r;
      rd_data[`IOPS_ST_GSR] = global_set_reset_r;
      rd_data[`IOPS_ST_GTS] = global_three_state_r;
      rd_data[`IOPS_ST_GWE] = global_write_enable_r;
      rd_data[`IOPS_ST_INIT] = init_status_r;
      rd_data[`IOPS_ST_SELPIN] = config_pullup_select_n;
    end else if (wb_adr_i == `IOPS_ADDR_USED) begin
      rd_data[NUM_IO-1:0] = used_r;
    end else if (wb_adr_i == `IOPS_ADDR_SRINV) begin
      rd_data[NUM_IO-1:0] = srinv_r;
    end else if (wb_adr_i == `IOPS_ADDR_UPULL) begin
      rd_data[NUM_IO-1:0] = upull_r;
    end else if (wb_adr_i == `IOPS_ADDR_DOUT) begin
      rd_data[NUM_IO-1:0] = dout_r;
    end else if (wb_adr_i == `IOPS_ADDR_SELPIN) begin
      rd_data[`IOPS_SEL_OUT] = sel_out_r;
      rd_data[`IOPS_SEL_DRV] = sel_drv_r;
    end
  end

  // Read view doubles as the old value for byte-lane writes
  assign wr_merged = lane_merge(rd_data, wb_dat_i, wb_sel_i);

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      term_r <= `IOPS_TERM_PULLDOWN;
      gwe_dly_r <= `IOPS_GWE_DLY_RST;
      used_r <= {NUM_IO{1'b0}};
      srinv_r <= {NUM_IO{1'b0}};
      upull_r <= {NUM_IO{1'b0}};
      dout_r <= {NUM_IO{1'b0}};
      sel_out_r <= 1'b0;
      sel_drv_r <= 1'b0;
    end else begin
      // Unmapped addresses still acknowledge and read zero
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h0;
      if (wb_wr) begin
        if (wb_adr_i == `IOPS_ADDR_CTRL) begin
          term_r <= wr_merged[`IOPS_CTRL_TERM_MSB:`IOPS_CTRL_TERM_LSB];
          gwe_dly_r <= wr_merged[`IOPS_CTRL_DLY_MSB:`IOPS_CTRL_DLY_LSB];
        end else if (wb_adr_i == `IOPS_ADDR_USED) begin
          used_r <= wr_merged[NUM_IO-1:0];
        end else if (wb_adr_i == `IOPS_ADDR_SRINV) begin
          srinv_r <= wr_merged[NUM_IO-1:0];
        end else if (wb_adr_i == `IOPS_ADDR_UPULL) begin
          upull_r <= wr_merged[NUM_IO-1:0];
        end else if (wb_adr_i == `IOPS_ADDR_DOUT) begin
          // Data may be staged any time; pins drive only after release
          dout_r <= wr_merged[NUM_IO-1:0];
        end else if (wb_adr_i == `IOPS_ADDR_SELPIN && wb_sel_i[0]) begin
          sel_out_r <= wb_dat_i[`IOPS_SEL_OUT];
          sel_drv_r <= wb_dat_i[`IOPS_SEL_DRV];
        end
      end
    end
  end

endmodule

`default_nettype wire

// ### iops_sequencer_assertions.sv
// Concurrent checks on the ports of the I/O power-up sequencer
`timescale 1ns/1ns
`default_nettype none
module iops_seq_chk #(
  parameter NUM_IO = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic vccint_ok,
  input wire logic vccaux_ok,
  input wire logic vcco2_ok,
  input wire logic config_pullup_select_n,
  input wire logic config_mode_sel_0,
  input wire logic config_mode_sel_1,
  input wire logic config_mode_sel_2,
  input wire logic init_status_r,
  input wire logic [2:0] config_mode_r,
  input wire logic global_set_reset_r,
  input wire logic global_three_state_r,
  input wire logic global_write_enable_r,
  input wire logic [NUM_IO-1:0] io_oe_n_r,
  input wire logic [NUM_IO-1:0] io_pullup_en_r,
  input wire logic [NUM_IO-1:0] io_pulldown_en_r,
  input wire logic [NUM_IO-1:0] io_block_cell_init_r,
  input wire logic sel_pin_weak_pullup_r,
  input wire logic sel_pin_oe_n_r
);
  wire sup_all = vccint_ok & vccaux_ok & vcco2_ok;
  wire [2:0] straps = {config_mode_sel_2, config_mode_sel_1, config_mode_sel_0};
  // Pin outputs lag the held globals by one cycle on a restart, hence the $past guards
  wire pre_user = global_three_state_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ****************************************
  // Start-up order and pin states
  // ****************************************
  gts_after_gsr_a: assert property (
    $fell(global_three_state_r) |-> !$past(global_set_reset_r)) else $error("early three-state release");
  gwe_after_gts_a: assert property (
    global_write_enable_r |-> !global_three_state_r) else $error("write enable before three-state release");
  gwe_one_cycle_a: assert property (
    $fell(global_three_state_r) |-> !global_write_enable_r ##1 global_write_enable_r) else $error("write enable delay wrong");
  hiz_pre_user_a: assert property (
    pre_user && $past(pre_user) |-> io_oe_n_r == {NUM_IO{1'b1}}) else $error("driver active before user mode");
  pull_by_select_a: assert property (
    pre_user && $past(pre_user) && $past(rstn) |-> io_pullup_en_r == {NUM_IO{!$past(config_pullup_select_n)}}) else $error("pull-ups do not follow select pin");
  mode_capture_a: assert property (
    $rose(init_status_r) |-> config_mode_r == $past(straps)) else $error("mode not captured at init");
  init_waits_a: assert property (
    !init_status_r && !sup_all |=> !init_status_r) else $error("init ended without supplies");
  cell_reset_a: assert property (
    global_set_reset_r && $past(global_set_reset_r) |-> io_block_cell_init_r == '0) else $error("cell not low under set-reset");
  sel_pullup_a: assert property (
    pre_user && $past(pre_user) |-> sel_pin_weak_pullup_r && sel_pin_oe_n_r) else $error("select pin pull-up missing");
  term_single_a: assert property (
    !pre_user |-> (io_pullup_en_r & io_pulldown_en_r) == '0) else $error("pull-up and pull-down together");
  init_cov_c: cover property ($rose(init_status_r));
  user_cov_c: cover property ($rose(global_write_enable_r));
  loss_cov_c: cover property ($rose(global_three_state_r));
endmodule
bind iops_sequencer iops_seq_chk #(.NUM_IO(NUM_IO)) u_chk (.core_clk(core_clk), .rstn(rstn),
  .vccint_ok(vccint_ok), .vccaux_ok(vccaux_ok), .vcco2_ok(vcco2_ok),
  .config_pullup_select_n(config_pullup_select_n), .config_mode_sel_0(config_mode_sel_0),
  .config_mode_sel_1(config_mode_sel_1), .config_mode_sel_2(config_mode_sel_2),
  .init_status_r(init_status_r), .config_mode_r(config_mode_r),
  .global_set_reset_r(global_set_reset_r), .global_three_state_r(global_three_state_r),
  .global_write_enable_r(global_write_enable_r), .io_oe_n_r(io_oe_n_r),
  .io_pullup_en_r(io_pullup_en_r), .io_pulldown_en_r(io_pulldown_en_r),
  .io_block_cell_init_r(io_block_cell_init_r), .sel_pin_weak_pullup_r(sel_pin_weak_pullup_r),
  .sel_pin_oe_n_r(sel_pin_oe_n_r));
`default_nettype wire

// ### test_iops_sequencer.sv
// Self-checking bench for the I/O power-up sequencer
`timescale 1ns/1ns
`default_nettype none
`include "iops_defines.vh"
module test_iops_sequencer;
  logic core_clk, rstn, cfg_load_done, sel_open, sel_level, wb_we_i, wb_cyc_i, wb_stb_i;
  logic [2:0] sup_on, mode, config_mode_r;
  logic [7:0] wb_adr_i, io_oe_n_r, io_dout_r, io_pullup_en_r, io_pulldown_en_r;
  logic [7:0] io_block_cell_init_r;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [3:0] wb_sel_i;
  logic vccint_ok, vccaux_ok, vcco2_ok, config_pullup_select_n, init_status_r, wb_ack_o;
  logic global_set_reset_r, global_three_state_r, global_write_enable_r;
  logic sel_pin_weak_pullup_r, sel_pin_oe_n_r, sel_pin_out_r;
  int n_errors = 0;
  int num_checks = 0;
  iops_sequencer dut (.core_clk, .rstn, .vccint_ok, .vccaux_ok, .vcco2_ok,
    .config_pullup_select_n, .config_mode_sel_0(mode[0]), .config_mode_sel_1(mode[1]),
    .config_mode_sel_2(mode[2]), .cfg_load_done, .init_status_r, .config_mode_r,
    .global_set_reset_r, .global_three_state_r, .global_write_enable_r, .io_oe_n_r,
    .io_dout_r, .io_pullup_en_r, .io_pulldown_en_r, .io_block_cell_init_r,
    .sel_pin_weak_pullup_r, .sel_pin_oe_n_r, .sel_pin_out_r, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o);
  iops_board_model board (.core_clk, .sup_on, .sel_open, .sel_level, .sel_pin_weak_pullup_r,
    .sel_pin_oe_n_r, .sel_pin_out_r, .vccint_ok, .vccaux_ok, .vcco2_ok,
    .config_pullup_select_n);
  // ****************************************
  // Bus and check helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1) @(posedge core_clk);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    tick(5000);
    n_errors++;
    final_report;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rstn = 1'b0;
    sup_on = 3'h0;
    mode = 3'h5;
    sel_open = 1'b0;
    sel_level = 1'b0;
    cfg_load_done = 1'b1;
    {wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    tick(16);
    rstn <= 1'b1;
    wb(1'b1, `IOPS_ADDR_USED, 32'h0F);
    wb(1'b1, `IOPS_ADDR_SRINV, 32'h30);
    wb(1'b1, `IOPS_ADDR_UPULL, 32'h03);
    wb(1'b1, `IOPS_ADDR_DOUT, 32'hA5);
    wb(1'b1, `IOPS_ADDR_CTRL, 32'h04);
    sup_on <= 3'h3;
    tick(30);
    sup_on <= 3'h6;
    tick(30);
    chk(init_status_r, 0);
    chk(global_set_reset_r, 1);
    chk(io_oe_n_r, 8'hFF);
    chk(io_pullup_en_r, 8'hFF);
    sup_on <= 3'h7;
    for (int i = 0; i < 80 && init_status_r !== 1'b1; i++) @(posedge core_clk);
    chk(config_mode_r, 3'h5);
    mode <= 3'h2;
    for (int i = 0; i < 20 && global_write_enable_r !== 1'b1; i++) @(posedge core_clk);
    tick(3);
    chk(config_mode_r, 3'h5);
    wb(1'b0, `IOPS_ADDR_STATUS, 32'h0);
    chk(rd, 32'h32D);
    chk(io_oe_n_r, 8'hF0);
    chk(io_dout_r & 8'h0F, 8'h05);
    chk(io_pulldown_en_r, 8'hF0);
    chk(io_pullup_en_r, 8'h03);
    chk(io_block_cell_init_r, 8'h30);
    chk(sel_pin_weak_pullup_r, 0);
    wb(1'b1, `IOPS_ADDR_SELPIN, 32'h3);
    tick(2);
    chk(config_pullup_select_n, 1);
    for (int t = 0; t < 3; t++) begin
      wb(1'b1, `IOPS_ADDR_CTRL, 32'h04 | t);
      tick(2);
      chk(io_pullup_en_r, (t == 1) ? 8'hF3 : 8'h03);
      chk(io_pulldown_en_r, (t == 0) ? 8'hF0 : 8'h00);
    end
    wb(1'b1, 8'h1C, 32'hFF);
    wb(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, `IOPS_ADDR_USED, 32'h0);
    chk(rd, 32'h0F);
    sel_open <= 1'b1;
    sup_on <= 3'h5;
    cfg_load_done <= 1'b0;
    tick(6);
    chk(init_status_r, 0);
    chk(global_set_reset_r, 1);
    chk(io_oe_n_r, 8'hFF);
    chk(sel_pin_weak_pullup_r, 1);
    chk(io_pullup_en_r, 8'h00);
    sup_on <= 3'h7;
    for (int i = 0; i < 80 && init_status_r !== 1'b1; i++) @(posedge core_clk);
    tick(4);
    // Loading not finished: everything still held
    chk(global_set_reset_r, 1);
    chk(io_oe_n_r, 8'hFF);
    chk(io_pullup_en_r, 8'h00);
    cfg_load_done <= 1'b1;
    for (int i = 0; i < 20 && global_three_state_r !== 1'b0; i++) @(posedge core_clk);
    chk(global_set_reset_r, 0);
    chk(global_write_enable_r, 0);
    @(posedge core_clk);
    chk(global_write_enable_r, 1);
    final_report;
  end
endmodule
`default_nettype wire
